// ==== include/wwd_pkg.sv ====
// constants, field layouts and carrier types of the windowed watchdog
// Function
// - a 12-bit down counter is loaded from the mode register load value
// - the counter decrements once per slow clock divided by 128
// - after reset load value is 0xFFF, watchdog runs, fault reset enabled
// - only the first mode write is taken until the next processor reset
// - writing mode reloads the counter with the new value and restarts it
// - an accepted restart reloads the counter and restarts the prescaler
// - control writes need key 0xA5 in bits 31:24; bit 0 asks restart
// - underflow sets the underflow flag and, if enabled, the fault line
// - restart above the delta window sets error and fault, even disabled
// - delta window at or above load value allows restart at any count
// - interrupt follows either flag enabled in irq enable, only while fault irq enable is one
// - with fault reset enable, fault requests all resets or processor only
// - a watchdog reset resets processor and watchdog and clears the flags
// - status read or any reset clears flags, interrupt and fault line
// - flags are sticky until the next status read or an irq clear write of their bit
// - counter stops in debug or idle when the matching halt bit is one
// - the disable bit disables the watchdog, clear leaves it enabled
package wwd_pkg;

    // register byte offsets
    localparam logic [7:0]  OFF_CONTROL   = 8'h00;
    localparam logic [7:0]  OFF_MODE      = 8'h04;
    localparam logic [7:0]  OFF_STATUS    = 8'h08;
    localparam logic [7:0]  OFF_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_EN    = 8'h10;

    // control register layout
    localparam logic [7:0]  CTL_KEY       = 8'hA5;
    localparam int          CTL_KEY_MSB   = 31;
    localparam int          CTL_KEY_LSB   = 24;
    localparam int          CTL_RESTART   = 0;

    // status register layout
    localparam int          ST_UNDERFLOW  = 0;
    localparam int          ST_ERROR      = 1;

    // reset values and the mode write mask
    localparam logic [31:0] MODE_RESET    = 32'h3FFF2FFF;
    localparam logic [31:0] MODE_WMASK    = 32'h3FFFFFFF;
    localparam logic [11:0] COUNT_RESET   = 12'hFFF;
    localparam logic [1:0]  IRQ_EN_RESET  = 2'h3;

    // counter geometry
    localparam int          COUNT_W       = 12;
    localparam int          PRESCALE_DIV  = 128;

    // mode register fields, msb first
    typedef struct packed {
        logic [1:0]  reserved;
        logic        idle_halt;
        logic        debug_halt;
        logic [11:0] delta_window;
        logic        disable_bit;
        logic        processor_only_reset;
        logic        fault_reset_enable;
        logic        fault_irq_enable;
        logic [11:0] load_value;
    } wwd_mode_t;

    // one register bus access
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wwd_req_t;

    // fault requests towards the reset controller
    typedef struct packed {
        logic fault;
        logic req_all;
        logic req_proc;
    } wwd_fault_t;

endpackage : wwd_pkg

// ==== hdl/wwd_prescaler.sv ====
// slow clock synchroniser and divide-by-128 tick generator
`timescale 1ns/1ps
`default_nettype none
module wwd_prescaler
    import wwd_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic slow_clk_i,
    input  wire logic clear_i,
    output logic      tick_o
);
    localparam int DW = $clog2(DIV);

    logic          slow_meta;
    logic          slow_sync;
    logic          slow_last;
    logic [DW-1:0] div_cnt;
    wire           slow_rise;
    wire           wrap;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser, then a third flop for the edge
    always_ff @(posedge clk_i) begin
        slow_meta <= slow_clk_i;
        slow_sync <= slow_meta;
        slow_last <= slow_sync;
    end

    assign slow_rise = slow_sync & ~slow_last;
    assign wrap      = slow_rise && (div_cnt == DW'(DIV - 1));

    // clear restarts the division so a restart gets a full period
    always_ff @(posedge clk_i) begin
        if (reset_i || clear_i) begin
            div_cnt <= '0;
            tick_o  <= 1'b0;
        end else begin
            tick_o <= wrap;
            if (slow_rise) begin
                div_cnt <= wrap ? '0 : div_cnt + DW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_quiet8;
        !tick_o [*8];
    endsequence

    a_tick_spacing: assert property (tick_o |=> s_quiet8)
        else $error("prescaler ticks closer than eight cycles");

endmodule : wwd_prescaler
`default_nettype wire

// ==== hdl/wwd_top.sv ====
// windowed watchdog: registers, window check, counter, flags and faults
`timescale 1ns/1ps
`default_nettype none
module wwd_top
    import wwd_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        SLOW_CLK_I,
    input  wire logic        DEBUG_I,
    input  wire logic        IDLE_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    output logic             IRQ_O,
    output logic             FAULT_O,
    output logic             RESET_REQ_ALL_O,
    output logic             RESET_REQ_PROC_O
);

    ////////////////////////////////////////////////////////////////////////
    // state
    wwd_mode_t    mode;
    logic         mode_locked;
    logic [11:0]  count;
    logic         unf_flag;
    logic         err_flag;
    logic [1:0]   irq_en;
    logic         dbg_meta;
    logic         dbg_sync;
    logic         idle_meta;
    logic         idle_sync;
    logic         tick;

    // decode and next values
    wwd_req_t     req;
    wwd_fault_t   next_fault;
    wire          wr_ctl;
    wire          wr_mode;
    wire          wr_clr;
    wire          wr_irq_en;
    wire          rd_status;
    wire          key_ok;
    wire          restart_req;
    wire          in_window;
    wire          restart_ok;
    wire          restart_bad;
    wire          mode_wr_ok;
    wire          halted;
    wire          running;
    wire          underflow_ev;
    wire          pre_clear;
    wire [11:0]   next_count;
    wire          next_unf;
    wire          next_err;
    wire          next_irq;
    wire          next_irq_fen;
    wire [1:0]    next_irq_en;
    wwd_mode_t    wr_mode_val;
    wire [31:0]   next_rdata;
    wire          clr_unf;
    wire          clr_err;

    ////////////////////////////////////////////////////////////////////////
    // bus access travels as one struct
    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    // address decode; no wait states ever
    assign wr_ctl    = req.wr && (req.addr == OFF_CONTROL);
    assign wr_mode   = req.wr && (req.addr == OFF_MODE);
    assign wr_clr    = req.wr && (req.addr == OFF_IRQ_CLEAR);
    assign wr_irq_en = req.wr && (req.addr == OFF_IRQ_EN);
    assign rd_status = req.rd && (req.addr == OFF_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // debug and idle come from other logic: two flops before any use
    always_ff @(posedge REF_CLK_I) begin
        dbg_meta  <= DEBUG_I;
        dbg_sync  <= dbg_meta;
        idle_meta <= IDLE_I;
        idle_sync <= idle_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler, restarted by every accepted restart and every taken mode write
    wwd_prescaler #(
        .DIV        (PRESCALE_DIV)
    ) u_prescaler (
        .clk_i      (REF_CLK_I),
        .reset_i    (RESET_I),
        .slow_clk_i (SLOW_CLK_I),
        .clear_i    (pre_clear),
        .tick_o     (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // restart command: wrong key means the whole write is dropped
    assign key_ok      = req.wdata[CTL_KEY_MSB:CTL_KEY_LSB] == CTL_KEY;
    assign restart_req = wr_ctl && key_ok && req.wdata[CTL_RESTART];

    // window check runs even while disabled
    // a delta at or above the load value opens the whole range
    assign in_window   = (count <= mode.delta_window) ||
                         (mode.delta_window >= mode.load_value);
    assign restart_ok  = restart_req && in_window;
    assign restart_bad = restart_req && !in_window;

    // mode register takes its first write only
    assign mode_wr_ok  = wr_mode && !mode_locked;

    ////////////////////////////////////////////////////////////////////////
    // halting and disabling both freeze the count
    assign halted  = (dbg_sync && mode.debug_halt) ||
                     (idle_sync && mode.idle_halt);
    assign running = !mode.disable_bit && !halted;

    // underflow is the tick that would take the count below zero
    assign underflow_ev = tick && running && (count == '0) &&
                          !restart_ok && !mode_wr_ok;

    // an accepted restart or a taken mode write restarts the division, so a full period follows
    assign pre_clear = restart_ok || mode_wr_ok;

    // counter next value, reloads take priority over counting
    assign next_count = mode_wr_ok ? req.wdata[11:0] :
                        (restart_ok || underflow_ev) ? mode.load_value :
                        (tick && running) ? count - 12'h001 :
                        count;

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: an event in the clearing cycle wins over the clear
    assign clr_unf  = rd_status || (wr_clr && req.wdata[ST_UNDERFLOW]);
    assign clr_err  = rd_status || (wr_clr && req.wdata[ST_ERROR]);
    assign next_unf = underflow_ev || (unf_flag && !clr_unf);
    assign next_err = restart_bad || (err_flag && !clr_err);

    // fault line: underflow only when reset is enabled, error always
    assign next_fault.fault    = (underflow_ev && mode.fault_reset_enable) ||
                                 restart_bad ||
                                 (FAULT_O && !rd_status);
    // scope of the requested reset
    assign next_fault.req_all  = next_fault.fault && mode.fault_reset_enable &&
                                 !mode.processor_only_reset;
    assign next_fault.req_proc = next_fault.fault && mode.fault_reset_enable &&
                                 mode.processor_only_reset;

    // interrupt from next flags, mask and enable, so a write shows next cycle
    assign wr_mode_val  = req.wdata & MODE_WMASK;
    assign next_irq_fen = mode_wr_ok ? wr_mode_val.fault_irq_enable : mode.fault_irq_enable;
    assign next_irq_en  = wr_irq_en ? req.wdata[1:0] : irq_en;
    assign next_irq     = next_irq_fen && |({next_err, next_unf} & next_irq_en);

    ////////////////////////////////////////////////////////////////////////
    // read mux; status shows the flags as they were before the clear
    assign next_rdata =
        !req.rd                  ? 32'h00000000 :
        (req.addr == OFF_MODE)   ? (mode & MODE_WMASK) :
        (req.addr == OFF_STATUS) ? {30'h00000000, err_flag, unf_flag} :
        (req.addr == OFF_IRQ_EN) ? {30'h00000000, irq_en} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // mode register and its lock; reset reopens it
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            mode        <= MODE_RESET;
            mode_locked <= 1'b0;
        end else if (mode_wr_ok) begin
            mode        <= req.wdata & MODE_WMASK;
            mode_locked <= 1'b1;
        end
    end

    // down counter; the reset value lets the watchdog run at power-up
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            count <= COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // flags and interrupt mask; any reset clears the flags
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            unf_flag <= 1'b0;
            err_flag <= 1'b0;
            irq_en   <= IRQ_EN_RESET;
        end else begin
            unf_flag <= next_unf;
            err_flag <= next_err;
            if (wr_irq_en) begin
                irq_en <= req.wdata[1:0];
            end
        end
    end

    // registered outputs towards the system
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            RDATA_O          <= 32'h00000000;
            IRQ_O            <= 1'b0;
            FAULT_O          <= 1'b0;
            RESET_REQ_ALL_O  <= 1'b0;
            RESET_REQ_PROC_O <= 1'b0;
        end else begin
            RDATA_O          <= next_rdata;
            IRQ_O            <= next_irq;
            FAULT_O          <= next_fault.fault;
            RESET_REQ_ALL_O  <= next_fault.req_all;
            RESET_REQ_PROC_O <= next_fault.req_proc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the control path
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);

    sequence s_good_restart;
        restart_req && in_window && !mode_wr_ok;
    endsequence

    sequence s_bad_key;
        wr_ctl && !key_ok;
    endsequence

    sequence s_halted_tick;
        tick && halted && !restart_ok && !mode_wr_ok;
    endsequence

    a_key_refused: assert property (
        s_bad_key ##0 !underflow_ev ##0 !err_flag |=> !err_flag)
        else $error("write with a wrong key had an effect");

    a_restart_reload: assert property (
        s_good_restart |=> count == $past(mode.load_value))
        else $error("accepted restart did not reload the counter");

    a_window_error: assert property (
        restart_req && !in_window |=> err_flag && FAULT_O)
        else $error("restart outside window did not flag an error");

    a_mode_once: assert property (
        wr_mode && mode_locked |=> mode == $past(mode))
        else $error("second mode write changed the mode register");

    a_mode_reload: assert property (
        mode_wr_ok |=> count == $past(req.wdata[11:0]) &&
                       mode.load_value == count)
        else $error("mode write did not reload the counter");

    a_underflow_flag: assert property (
        tick && running && count == 12'h000 && !restart_ok && !mode_wr_ok
        |=> unf_flag && count == $past(mode.load_value))
        else $error("underflow not flagged or not reloaded");

    a_status_clear: assert property (
        rd_status && !underflow_ev && !restart_bad
        |=> !unf_flag && !err_flag && !FAULT_O && !IRQ_O)
        else $error("status read did not clear flags and fault");

    a_flag_sticky: assert property (
        unf_flag && !clr_unf |=> unf_flag)
        else $error("underflow flag dropped without a clear");

    a_irq_gate: assert property (
        IRQ_O == (mode.fault_irq_enable && |({err_flag, unf_flag} & irq_en)))
        else $error("interrupt does not follow the enabled flags");

    a_halt_hold: assert property (
        s_halted_tick |=> $stable(count))
        else $error("counter moved while halted");

    a_disabled_hold: assert property (
        mode.disable_bit && !restart_ok && !mode_wr_ok
        |=> $stable(count) && !$rose(unf_flag))
        else $error("disabled watchdog counted or underflowed");

    a_reset_scope: assert property (
        FAULT_O && mode.fault_reset_enable && $stable(mode)
        |-> (RESET_REQ_PROC_O == mode.processor_only_reset) &&
            (RESET_REQ_ALL_O  == !mode.processor_only_reset))
        else $error("reset request scope does not follow the mode");

    ////////////////////////////////////////////////////////////////////////
    // checks on counting, faults and the read port
    sequence s_plain_tick;
        tick && running && !restart_ok && !mode_wr_ok;
    endsequence

    sequence s_no_reload;
        !restart_ok && !mode_wr_ok;
    endsequence

    sequence s_tick_free;
        !tick [*8];
    endsequence

    a_count_step: assert property (
        s_plain_tick ##0 count != 12'h000 |=> count == $past(count) - 12'h001)
        else $error("counter did not step down on a tick");

    a_count_idle: assert property (
        s_no_reload ##0 !tick |=> $stable(count))
        else $error("counter moved without a tick");

    a_error_hold: assert property (
        restart_bad && !tick |=> $stable(count))
        else $error("restart outside window touched the counter");

    a_unf_fault: assert property (
        underflow_ev && mode.fault_reset_enable |=> FAULT_O)
        else $error("underflow with reset enabled raised no fault");

    a_fault_sticky: assert property (
        FAULT_O && !rd_status |=> FAULT_O)
        else $error("fault line dropped without a status read");

    a_err_sticky: assert property (
        err_flag && !clr_err |=> err_flag)
        else $error("error flag dropped without a clear");

    a_req_scope: assert property (
        (RESET_REQ_ALL_O || RESET_REQ_PROC_O) |-> FAULT_O &&
        !(RESET_REQ_ALL_O && RESET_REQ_PROC_O))
        else $error("reset request without fault or with both scopes");

    a_status_read: assert property (
        rd_status |=> RDATA_O == {30'h00000000, $past(err_flag), $past(unf_flag)})
        else $error("status read did not return the flags");

    a_mode_lock: assert property (
        mode_wr_ok |=> mode_locked && mode == $past(wr_mode_val))
        else $error("first mode write not taken or not locked");

    a_window_pass: assert property (
        restart_ok |=> !$rose(err_flag) && !$rose(FAULT_O))
        else $error("restart inside the window raised an error");

    a_prescale_restart: assert property (
        pre_clear |=> s_tick_free)
        else $error("prescaler ticked right after a reload");

endmodule : wwd_top
`default_nettype wire

// ==== sim/windowed_watchdog_timer_test.sv ====
// self-checking bench of the windowed watchdog: registers, window, faults, halts
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_test
    import wwd_pkg::*;
();

    localparam int LIMIT = 40000;

    logic        clk;
    logic        rst;
    logic        slow;
    logic        dbg;
    logic        idle;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq;
    logic        fault;
    logic        req_all;
    logic        req_proc;
    int          bad_count;
    int          check_count;
    int          cycles;
    logic [31:0] seed;
    logic [7:0]  key;
    logic [2:0]  slow_div;
    logic        rd_seen;
    logic [31:0] exp_q[$];
    string       name_q[$];

    ////////////////////////////////////////////////////////////////////////////////
    wwd_top dut (
        .REF_CLK_I        (clk),
        .RESET_I          (rst),
        .SLOW_CLK_I       (slow),
        .DEBUG_I          (dbg),
        .IDLE_I           (idle),
        .ADDR_I           (addr),
        .WDATA_I          (wdata),
        .WR_I             (wr),
        .RD_I             (rd),
        .RDATA_O          (rdata),
        .IRQ_O            (irq),
        .FAULT_O          (fault),
        .RESET_REQ_ALL_O  (req_all),
        .RESET_REQ_PROC_O (req_proc)
    );

    // clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // galois feedback for pseudo random data
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr

    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : check_word

    // levels are looked at mid-cycle, after the edge's updates landed
    task automatic check_bit(input string n, input logic e);
        logic g;
        @(negedge clk);
        g = (n == "irq") ? irq : (n == "fault") ? fault : (n == "all") ? req_all : req_proc;
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %b seen %b", n, e, g);
            bad_count++;
        end
    endtask : check_bit

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // the expected word is noted first, the monitor takes it off
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
    endtask : rd_reg

    task automatic restart();
        wr_reg(OFF_CONTROL, {CTL_KEY, 24'h000001});
    endtask : restart

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    // bounded wait, the following compare catches a miss
    task automatic wait_fault(input int n);
        for (int i = 0; i < n && fault !== 1'b1; i++) @(posedge clk);
    endtask : wait_fault

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // read monitor, slow clock of 8 cycles and the hang limit
    always @(posedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            check_word(name_q.pop_front(), exp_q.pop_front(), rdata);
        end
        rd_seen  <= rd && !rst;
        slow_div <= slow_div + 3'h1;
        if (slow_div[1:0] == 2'h3) begin
            slow <= ~slow;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence; a tick is 128 slow edges, about 1024 cycles
    initial begin
        rst = 1'b1; slow = 1'b0; dbg = 1'b0; idle = 1'b0; addr = 8'h00;
        wdata = 32'h00000000; wr = 1'b0; rd = 1'b0; bad_count = 0; check_count = 0;
        cycles = 0; slow_div = 3'h0; rd_seen = 1'b0; seed = 32'h5B6BF614; key = 8'h00;
        do_reset();
        rd_reg(OFF_MODE, MODE_RESET, "mode reset");
        rd_reg(OFF_STATUS, 32'h00000000, "status reset");
        // load 3, window 1, fault reset and irq enabled
        wr_reg(OFF_MODE, 32'h00013003);
        seed = lfsr(seed);
        wr_reg(OFF_MODE, seed);
        rd_reg(OFF_MODE, 32'h00013003, "mode once");
        seed = lfsr(seed);
        key = (seed[31:24] == CTL_KEY) ? ~seed[31:24] : seed[31:24];
        wr_reg(OFF_CONTROL, {key, seed[23:1], 1'b1});
        check_bit("fault", 1'b0);
        restart();
        check_bit("fault", 1'b1);
        check_bit("irq", 1'b1);
        check_bit("all", 1'b1);
        rd_reg(OFF_STATUS, 32'h00000002, "status early");
        check_bit("fault", 1'b0);
        check_bit("irq", 1'b0);
        // two and a half ticks on, count is 1, inside the window
        repeat (2500) @(posedge clk);
        restart();
        rd_reg(OFF_STATUS, 32'h00000000, "status in window");
        // with reload and prescaler restart no underflow before 4096 cycles
        repeat (3800) @(posedge clk);
        check_bit("fault", 1'b0);
        wait_fault(1000);
        check_bit("fault", 1'b1);
        rd_reg(OFF_STATUS, 32'h00000001, "status underflow");

        // load 0, window wide, debug and idle halt, processor only reset
        do_reset();
        check_bit("fault", 1'b0);
        wr_reg(OFF_MODE, 32'h3FFF7000);
        dbg  <= 1'b1;
        idle <= 1'b1;
        rd_reg(OFF_MODE, 32'h3FFF7000, "mode after reset");
        repeat (3000) @(posedge clk);
        check_bit("fault", 1'b0);
        restart();
        rd_reg(OFF_STATUS, 32'h00000000, "status wide window");
        dbg <= 1'b0;
        repeat (1500) @(posedge clk);
        idle <= 1'b0;
        check_bit("fault", 1'b0);
        wait_fault(1500);
        check_bit("fault", 1'b1);
        check_bit("proc", 1'b1);
        check_bit("all", 1'b0);
        wr_reg(OFF_IRQ_EN, 32'h00000000);
        check_bit("irq", 1'b0);
        wr_reg(OFF_IRQ_EN, 32'h00000003);
        check_bit("irq", 1'b1);
        wr_reg(OFF_IRQ_CLEAR, 32'h00000001);
        check_bit("irq", 1'b0);
        check_bit("fault", 1'b1);
        rd_reg(8'h20, 32'h00000000, "unmapped");
        rd_reg(OFF_IRQ_EN, 32'h00000003, "irq enable");

        // disabled: load 5, window 2, no reset or irq enable
        do_reset();
        wr_reg(OFF_MODE, 32'h00028005);
        restart();
        check_bit("fault", 1'b1);
        check_bit("irq", 1'b0);
        check_bit("all", 1'b0);
        // a running counter would underflow after 6144 cycles
        repeat (7000) @(posedge clk);
        rd_reg(OFF_STATUS, 32'h00000002, "status disabled");
        check_bit("fault", 1'b0);
        results();
    end

endmodule : windowed_watchdog_timer_test
`default_nettype wire
